/* bt_regs.vh */
// register offsets, field positions, reset values and timing counts for the byte timer
`ifndef BT_REGS_VH
`define BT_REGS_VH
// register offsets (register index on the plain port)
`define BT_ADDR_CTRL_B 4'h0
`define BT_ADDR_CTRL_A 4'h1
`define BT_ADDR_STATUS 4'h2
`define BT_ADDR_CAP_A 4'h3
`define BT_ADDR_CMP_A 4'h4
`define BT_ADDR_CNT 4'h5
`define BT_ADDR_CNT_MIR 4'h6
`define BT_ADDR_CAP_B 4'h7
`define BT_ADDR_CMP_B 4'h8
// timer_control_a fields
`define BT_A_CAP_IE 7
`define BT_A_CMP_IE 6
`define BT_A_OVF_IE 5
`define BT_A_FORCE_B 4
`define BT_A_FORCE_A 3
`define BT_A_LEVEL_B 2
`define BT_A_EDGE_A 1
`define BT_A_LEVEL_A 0
// timer_control_b fields
`define BT_B_PIN_A_EN 7
`define BT_B_PIN_B_EN 6
`define BT_B_PULSE 5
`define BT_B_PWM 4
`define BT_B_CLK_HI 3
`define BT_B_CLK_LO 2
`define BT_B_EDGE_B 1
// timer_status fields
`define BT_S_CAP_A 7
`define BT_S_CMP_A 6
`define BT_S_OVF 5
`define BT_S_CAP_B 4
`define BT_S_CMP_B 3
`define BT_S_DISABLE 2
// reset values and masks
`define BT_CTRL_RST 8'h00
`define BT_CTRL_B_MASK 8'hFE
`define BT_CNT_RST 8'hFC
// prescaler divisions
`define BT_DIV_4 14'h0003
`define BT_DIV_2 14'h0001
`define BT_DIV_8 14'h0007
`define BT_SLOW_DIV 14'h1F3F
`endif

/* bt_prescaler.v */
// prescaler producing the counter tick for the byte timer
`timescale 1ns/10ps
`default_nettype none
`include "bt_regs.vh"
module bt_prescaler
(
  // clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // control
  input wire freeze,
  input wire [1:0] clock_select,
  input wire slow_tick,
  // output
  output reg tick_r
);
  reg [13:0] div_r;
  reg [13:0] limit;
  // terminal count for the chosen division
  always @*
  begin
    case (clock_select)
      2'h0: limit = `BT_DIV_4;
      2'h1: limit = `BT_DIV_2;
      2'h2: limit = `BT_DIV_8;
      default: limit = `BT_SLOW_DIV;
    endcase
  end
  // slow source counts only its own ticks; freeze holds the count
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      div_r <= 14'h0000;
      tick_r <= 1'b0;
    end
    else if (freeze)
    begin
      tick_r <= 1'b0;
    end
    else if (clock_select != 2'h3 || slow_tick)
    begin
      if (div_r >= limit)
      begin
        div_r <= 14'h0000;
        tick_r <= 1'b1;
      end
      else
      begin
        div_r <= div_r + 14'h0001;
        tick_r <= 1'b0;
      end
    end
    else
    begin
      tick_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* bt_timer.v */
// byte timer: 8-bit counter with two captures, two compares, one-pulse and pwm modes
// Operation
// - all timer events drive one shared interrupt, gated by enables and global mask
// - capture interrupt enable passes either capture flag to the interrupt
// - compare interrupt enable passes either compare flag to the interrupt
// - overflow interrupt enable passes the overflow flag to the interrupt
// - force bits copy the level bit to an enabled compare pin outside pulse and pwm modes
// - compare b match copies level b to pin b; pulse and pwm use pin a
// - compare a match copies level a to enabled pin a
// - edge bit a picks rising or falling capture edge on pin a
// - edge bit b picks rising or falling capture edge on pin b
// - pin enables only route outputs; compare logic keeps running
// - pulse mode: edge on pin a starts one pulse, compare a sets length
// - pwm mode: compare a sets pulse length, compare b sets period
// - clock select picks divide by 4, 2, 8 or slow clock by 8000
// - capture flag a set by capture, pulse mode edge or pwm period; cleared via capture a access
// - compare flag a set on match outside pulse and pwm modes; cleared via compare a access
// - overflow flag set on FF to 00 wrap; counter mirror access keeps it
// - capture flag b set by capture b; cleared via capture b access
// - compare flag b set on match; cleared via compare b access
// - pwm mode never sets compare flags
// - disable bit freezes prescaler and counter and blanks compare pins
// - both counter registers read the count, reset to FC, write resets it
// - capture event copies the count into that input's capture register
// - pwm compare b match reloads the counter with FC
// - pulse mode edge reloads FC and drives level b onto pin a
// - pwm compare values are buffered until the period ends
// - any enabled interrupt can wake the processor from wait
`timescale 1ns/10ps
`default_nettype none
`include "bt_regs.vh"
module bt_timer
(
  // clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata_r,
  // system
  input wire slow_clk_tick,
  input wire irq_mask,
  output reg irq_r,
  output reg wake_r,
  // pins
  input wire capture_in_pin_a,
  input wire capture_in_pin_b,
  output reg compare_out_pin_a_r,
  output reg compare_out_pin_b_r,
  output reg compare_pin_a_oe_n_r,
  output reg compare_pin_b_oe_n_r
);
  reg [7:0] timer_control_a_r;
  reg [7:0] timer_control_b_r;
  reg timer_disable_r;
  reg [4:0] flag_r;
  reg [4:0] armed_r;
  reg [7:0] counter_r;
  reg [7:0] capture_a_value_r, capture_b_value_r;
  reg [7:0] cmp_a_buf_r, cmp_b_buf_r, cmp_a_act_r, cmp_b_act_r;
  reg [1:0] sync_a_r, sync_b_r;
  reg out_a_r, out_b_r, last_a_r, last_b_r, slow_sync0_r, slow_sync1_r, slow_last_r;
  wire tick, pwm_mode, pulse_mode, edge_a, edge_b, cap_a_evt, cap_b_evt;
  wire match_a, match_b, pwm_end, ovf_evt, cnt_wr, slow_tick, irq_nxt;
  wire [4:0] set_v, acc_v;
  // flag vector bit order: 4 cap a, 3 cmp a, 2 ovf, 1 cap b, 0 cmp b
  // ==========================================================
  // helper functions
  // ==========================================================
  // edge detect with selectable polarity
  function edge_hit;
    input prev;
    input cur;
    input rising;
    begin
      edge_hit = rising ? (~prev & cur) : (prev & ~cur);
    end
  endfunction
  // access to a register at the given address
  function acc_at;
    input [3:0] addr;
    input [3:0] want;
    input rd;
    input wr;
    begin
      acc_at = (rd | wr) && (addr == want);
    end
  endfunction
  // ==========================================================
  // pin synchronisers and edge detection
  // ==========================================================
  // two flops before any logic looks at a pin
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      sync_a_r <= 2'h0;
      sync_b_r <= 2'h0;
      last_a_r <= 1'b0;
      last_b_r <= 1'b0;
      slow_sync0_r <= 1'b0;
      slow_sync1_r <= 1'b0;
      slow_last_r <= 1'b0;
    end
    else
    begin
      sync_a_r <= {sync_a_r[0], capture_in_pin_a};
      sync_b_r <= {sync_b_r[0], capture_in_pin_b};
      last_a_r <= sync_a_r[1];
      last_b_r <= sync_b_r[1];
      slow_sync0_r <= slow_clk_tick;
      slow_sync1_r <= slow_sync0_r;
      slow_last_r <= slow_sync1_r;
    end
  end
  assign slow_tick = slow_sync1_r & ~slow_last_r;
  assign edge_a = edge_hit(last_a_r, sync_a_r[1], timer_control_a_r[`BT_A_EDGE_A]);
  assign edge_b = edge_hit(last_b_r, sync_b_r[1], timer_control_b_r[`BT_B_EDGE_B]);
  // ==========================================================
  // prescaler
  // ==========================================================
  bt_prescaler u_presc
  (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .freeze(timer_disable_r),
    .clock_select(timer_control_b_r[`BT_B_CLK_HI:`BT_B_CLK_LO]),
    .slow_tick(slow_tick),
    .tick_r(tick)
  );
  // ==========================================================
  // mode and event decode
  // ==========================================================
  // pwm wins when both mode bits are set
  assign pwm_mode = timer_control_b_r[`BT_B_PWM];
  assign pulse_mode = timer_control_b_r[`BT_B_PULSE] & ~pwm_mode;
  // capture on pin a is disconnected in both waveform modes
  assign cap_a_evt = edge_a & ~pwm_mode & ~pulse_mode;
  assign cap_b_evt = edge_b;
  // matches are judged on the count held for a whole tick
  assign match_a = tick & (counter_r == cmp_a_act_r);
  assign match_b = tick & (counter_r == cmp_b_act_r);
  assign pwm_end = pwm_mode & match_b;
  assign ovf_evt = tick & (counter_r == 8'hFF) & ~pwm_end;
  assign cnt_wr = reg_wr && (reg_addr == `BT_ADDR_CNT || reg_addr == `BT_ADDR_CNT_MIR);
  // ==========================================================
  // counter
  // ==========================================================
  // software write and pulse mode edge reload at once, even while disabled; the pwm reload waits for a tick
  always @(posedge ref_clk)
  begin
    if (sys_rst)
      counter_r <= `BT_CNT_RST;
    else if (cnt_wr)
      counter_r <= `BT_CNT_RST;
    else if (pulse_mode && edge_a)
      counter_r <= `BT_CNT_RST;
    else if (pwm_end)
      counter_r <= `BT_CNT_RST;
    else if (tick)
      counter_r <= counter_r + 8'h01;
  end
  // ==========================================================
  // capture registers
  // ==========================================================
  // pulse mode edge still loads capture a with the reload value
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      capture_a_value_r <= 8'h00;
      capture_b_value_r <= 8'h00;
    end
    else
    begin
      if (cap_a_evt)
        capture_a_value_r <= counter_r;
      else if (pulse_mode && edge_a)
        capture_a_value_r <= `BT_CNT_RST;
      if (cap_b_evt)
        capture_b_value_r <= counter_r;
    end
  end
  // ==========================================================
  // compare buffers
  // ==========================================================
  // in pwm the active copy moves only at the period end to avoid output spikes
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cmp_a_buf_r <= 8'h00;
      cmp_b_buf_r <= 8'h00;
      cmp_a_act_r <= 8'h00;
      cmp_b_act_r <= 8'h00;
    end
    else
    begin
      if (reg_wr && reg_addr == `BT_ADDR_CMP_A)
        cmp_a_buf_r <= reg_wdata;
      if (reg_wr && reg_addr == `BT_ADDR_CMP_B)
        cmp_b_buf_r <= reg_wdata;
      if (!pwm_mode || pwm_end)
      begin
        cmp_a_act_r <= (reg_wr && reg_addr == `BT_ADDR_CMP_A && !pwm_mode) ?
          reg_wdata : cmp_a_buf_r;
        cmp_b_act_r <= (reg_wr && reg_addr == `BT_ADDR_CMP_B && !pwm_mode) ?
          reg_wdata : cmp_b_buf_r;
      end
    end
  end
  // ==========================================================
  // flags
  // ==========================================================
  assign set_v[4] = cap_a_evt | (pulse_mode & edge_a) | pwm_end;
  assign set_v[3] = match_a & ~pwm_mode & ~pulse_mode;
  assign set_v[2] = ovf_evt;
  assign set_v[1] = cap_b_evt;
  assign set_v[0] = match_b & ~pwm_mode;
  // only the main counter address clears overflow; the mirror does not
  assign acc_v[4] = acc_at(reg_addr, `BT_ADDR_CAP_A, reg_rd, reg_wr);
  assign acc_v[3] = acc_at(reg_addr, `BT_ADDR_CMP_A, reg_rd, reg_wr);
  assign acc_v[2] = acc_at(reg_addr, `BT_ADDR_CNT, reg_rd, reg_wr);
  assign acc_v[1] = acc_at(reg_addr, `BT_ADDR_CAP_B, reg_rd, reg_wr);
  assign acc_v[0] = acc_at(reg_addr, `BT_ADDR_CMP_B, reg_rd, reg_wr);
  // a new event in the clearing cycle wins over the clear
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      flag_r <= 5'h00;
      armed_r <= 5'h00;
    end
    else
    begin
      flag_r <= set_v | (flag_r & ~(armed_r & acc_v));
      if (reg_rd && reg_addr == `BT_ADDR_STATUS)
        armed_r <= (armed_r & ~acc_v) | flag_r;
      else
        armed_r <= armed_r & ~acc_v & flag_r;
    end
  end
  // ==========================================================
  // control registers
  // ==========================================================
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      timer_control_a_r <= `BT_CTRL_RST;
      timer_control_b_r <= `BT_CTRL_RST;
      timer_disable_r <= 1'b0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `BT_ADDR_CTRL_A)
        timer_control_a_r <= reg_wdata;
      if (reg_addr == `BT_ADDR_CTRL_B)
        timer_control_b_r <= reg_wdata & `BT_CTRL_B_MASK;
      if (reg_addr == `BT_ADDR_STATUS)
        timer_disable_r <= reg_wdata[`BT_S_DISABLE];
    end
  end
  // ==========================================================
  // compare outputs
  // ==========================================================
  // internal levels update even with the pin disabled; the pin enable only routes
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      out_a_r <= 1'b0;
      out_b_r <= 1'b0;
    end
    else if (pwm_mode)
    begin
      if (pwm_end)
        out_a_r <= timer_control_a_r[`BT_A_LEVEL_B];
      else if (match_a)
        out_a_r <= timer_control_a_r[`BT_A_LEVEL_A];
    end
    else if (pulse_mode)
    begin
      if (edge_a)
        out_a_r <= timer_control_a_r[`BT_A_LEVEL_B];
      else if (match_a)
        out_a_r <= timer_control_a_r[`BT_A_LEVEL_A];
    end
    else
    begin
      if (match_a || timer_control_a_r[`BT_A_FORCE_A])
        out_a_r <= timer_control_a_r[`BT_A_LEVEL_A];
      if (match_b || timer_control_a_r[`BT_A_FORCE_B])
        out_b_r <= timer_control_a_r[`BT_A_LEVEL_B];
    end
  end
  // pins are released while disabled, so the io port can take them over
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      compare_out_pin_a_r <= 1'b0;
      compare_out_pin_b_r <= 1'b0;
      compare_pin_a_oe_n_r <= 1'b1;
      compare_pin_b_oe_n_r <= 1'b1;
    end
    else
    begin
      compare_out_pin_a_r <= out_a_r;
      compare_out_pin_b_r <= out_b_r;
      compare_pin_a_oe_n_r <= ~timer_control_b_r[`BT_B_PIN_A_EN] | timer_disable_r;
      compare_pin_b_oe_n_r <= ~timer_control_b_r[`BT_B_PIN_B_EN] | timer_disable_r;
    end
  end
  // ==========================================================
  // interrupt request
  // ==========================================================
  assign irq_nxt = (timer_control_a_r[`BT_A_CAP_IE] & (flag_r[4] | flag_r[1]))
    | (timer_control_a_r[`BT_A_CMP_IE] & (flag_r[3] | flag_r[0]))
    | (timer_control_a_r[`BT_A_OVF_IE] & flag_r[2]);
  // wake ignores the global mask, as wait exit needs only an enabled event
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      irq_r <= 1'b0;
      wake_r <= 1'b0;
    end
    else
    begin
      irq_r <= irq_nxt & ~irq_mask;
      wake_r <= irq_nxt;
    end
  end
  // ==========================================================
  // read data
  // ==========================================================
  // unmapped addresses read zero; data stand one cycle after the strobe
  always @(posedge ref_clk)
  begin
    if (sys_rst)
      reg_rdata_r <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `BT_ADDR_CTRL_B: reg_rdata_r <= timer_control_b_r;
        `BT_ADDR_CTRL_A: reg_rdata_r <= timer_control_a_r;
        `BT_ADDR_STATUS: reg_rdata_r <= {flag_r[4], flag_r[3], flag_r[2], flag_r[1], flag_r[0],
          timer_disable_r, 2'h0};
        `BT_ADDR_CAP_A: reg_rdata_r <= capture_a_value_r;
        `BT_ADDR_CMP_A: reg_rdata_r <= cmp_a_buf_r;
        `BT_ADDR_CNT: reg_rdata_r <= counter_r;
        `BT_ADDR_CNT_MIR: reg_rdata_r <= counter_r;
        `BT_ADDR_CAP_B: reg_rdata_r <= capture_b_value_r;
        `BT_ADDR_CMP_B: reg_rdata_r <= cmp_b_buf_r;
        default: reg_rdata_r <= 8'h00;
      endcase
    end
    else
      reg_rdata_r <= 8'h00;
  end
endmodule
`default_nettype wire

/* bt_timer_checker.sv */
// assertion checker for the byte timer, bound to its top module
`timescale 1ns/10ps
`default_nettype none
module bt_timer_checker
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_r,
  // system
  input wire logic slow_clk_tick,
  input wire logic irq_mask,
  input wire logic irq_r,
  input wire logic wake_r,
  // pins
  input wire logic capture_in_pin_a,
  input wire logic capture_in_pin_b,
  input wire logic compare_out_pin_a_r,
  input wire logic compare_out_pin_b_r,
  input wire logic compare_pin_a_oe_n_r,
  input wire logic compare_pin_b_oe_n_r
);
  // ==========
  // shadow controls, so pin routing can be judged from the port alone
  logic [7:0] ctrl_a_r;
  logic [7:0] ctrl_b_r;
  logic dis_r;
  wire logic drive_a = ctrl_b_r[7] & ~dis_r;
  wire logic drive_b = ctrl_b_r[6] & ~dis_r;
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      ctrl_a_r <= 8'h00;
      ctrl_b_r <= 8'h00;
      dis_r <= 1'b0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == 4'h1)
        ctrl_a_r <= reg_wdata;
      if (reg_addr == 4'h0)
        ctrl_b_r <= reg_wdata & 8'hFE;
      if (reg_addr == 4'h2)
        dis_r <= reg_wdata[2];
    end
  end
  // ==========
  // properties; two-cycle antecedents absorb the registered outputs
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  AST_MASK_BLOCKS:
    assert property (irq_mask [*2] |-> !irq_r) else $error("interrupt while masked");
  AST_IRQ_WAKES:
    assert property (irq_r |-> wake_r) else $error("interrupt without wake request");
  AST_NO_SOURCE:
    assert property ((ctrl_a_r[7:5] == 3'b000) [*2] |-> !wake_r)
    else $error("wake request with all enables off");
  AST_PIN_A_OFF:
    assert property (!drive_a [*2] |-> compare_pin_a_oe_n_r) else $error("pin a driven");
  AST_PIN_B_OFF:
    assert property (!drive_b [*2] |-> compare_pin_b_oe_n_r) else $error("pin b driven");
  AST_PIN_A_ON:
    assert property (drive_a [*2] |-> !compare_pin_a_oe_n_r) else $error("pin a released");
  AST_DIS_READ:
    assert property (reg_rd && reg_addr == 4'h2 |=> reg_rdata_r[2:0] == {$past(dis_r), 2'b00})
    else $error("status low bits wrong");
  AST_CTRLB_READ:
    assert property (reg_rd && reg_addr == 4'h0 |=> reg_rdata_r == $past(ctrl_b_r))
    else $error("control b readback wrong");
  AST_CNT_WRITE:
    assert property ((reg_wr && reg_addr == 4'h5) ##2 (reg_rd && reg_addr == 4'h5)
      |=> reg_rdata_r inside {8'hFC, 8'hFD}) else $error("counter not reset by write");
endmodule
bind bt_timer bt_timer_checker chk_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata_r(reg_rdata_r), .slow_clk_tick(slow_clk_tick), .irq_mask(irq_mask),
  .irq_r(irq_r), .wake_r(wake_r), .capture_in_pin_a(capture_in_pin_a),
  .capture_in_pin_b(capture_in_pin_b), .compare_out_pin_a_r(compare_out_pin_a_r),
  .compare_out_pin_b_r(compare_out_pin_b_r), .compare_pin_a_oe_n_r(compare_pin_a_oe_n_r),
  .compare_pin_b_oe_n_r(compare_pin_b_oe_n_r));
`default_nettype wire

/* bt_pin_model.sv */
// model of the circuitry on the timer's capture and compare pins
`timescale 1ns/10ps
`default_nettype none
module bt_pin_model
(
  // clock
  input wire logic ref_clk,
  // capture levels requested by the bench
  input wire logic req_a,
  input wire logic req_b,
  output logic cap_a,
  output logic cap_b,
  // compare pins from the timer
  input wire logic out_a,
  input wire logic out_b,
  input wire logic oe_a_n,
  input wire logic oe_b_n,
  output logic line_a,
  output logic line_b
);
  logic last_a = 1'b0;
  logic last_b = 1'b0;
  // idle lines sit high before the first edge
  initial
  begin
    cap_a = 1'b1;
    cap_b = 1'b1;
  end
  // capture sources move just after an edge, like a board driver
  always @(posedge ref_clk)
  begin
    cap_a <= req_a;
    cap_b <= req_b;
    if (!oe_a_n)
      last_a <= out_a;
    if (!oe_b_n)
      last_b <= out_b;
  end
  // no pull resistor: a released pin shows the opposite of its last level
  assign line_a = oe_a_n ? ~last_a : out_a;
  assign line_b = oe_b_n ? ~last_b : out_b;
endmodule
`default_nettype wire

/* bt_timer_test.sv */
// self-checking testbench for the byte timer
`timescale 1ns/10ps
`default_nettype none
module bt_timer_test;
  // ==========
  // stimulus, observation and bookkeeping
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic irq_mask = 1'b0;
  logic req_a = 1'b1;
  logic req_b = 1'b1;
  logic slow_run = 1'b0;
  logic [1:0] slow_div = 2'b00;
  logic [7:0] reg_rdata_r;
  logic irq_r, wake_r, cap_a, cap_b, out_a, out_b, oe_a_n, oe_b_n, line_a, line_b;
  logic [7:0] v;
  logic [7:0] w;
  int bad_count = 0;
  int samples_checked = 0;
  int c;
  logic [3:0] rst_addr [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hF};
  logic [1:0] sel_tab [4] = '{2'd0, 2'd2, 2'd3, 2'd1};
  int gap [4] = '{32, 64, 32000, 16};
  always #20 ref_clk = ~ref_clk;
  // slow oscillator stand-in: one rising edge every four clocks while running
  always @(posedge ref_clk)
    if (slow_run)
      slow_div <= slow_div + 2'd1;
  bt_timer dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
    .slow_clk_tick(slow_div[1]), .irq_mask(irq_mask), .irq_r(irq_r), .wake_r(wake_r),
    .capture_in_pin_a(cap_a), .capture_in_pin_b(cap_b), .compare_out_pin_a_r(out_a),
    .compare_out_pin_b_r(out_b), .compare_pin_a_oe_n_r(oe_a_n), .compare_pin_b_oe_n_r(oe_b_n));
  bt_pin_model pins_u (.ref_clk(ref_clk), .req_a(req_a), .req_b(req_b), .cap_a(cap_a),
    .cap_b(cap_b), .out_a(out_a), .out_b(out_b), .oe_a_n(oe_a_n), .oe_b_n(oe_b_n),
    .line_a(line_a), .line_b(line_b));
  // ==========
  // register port cycles, comparisons and the verdict
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_r;
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic st(input logic [7:0] m, input logic [7:0] e);
    rd(4'h2, v);
    chk("status", e, v & m);
  endtask
  // cycles until the next low-to-high move of pin a, bounded
  task automatic next_rise(output int n);
    logic p;
    n = 0;
    p = 1'b1;
    while (!(p === 1'b0 && line_a === 1'b1))
    begin
      p = line_a;
      @(posedge ref_clk);
      #1 n++;
      if (n > 99)
      begin
        bad_count++;
        print_verdict;
      end
    end
  endtask
  // hang guard: an overlong run counts as a mismatch
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    bad_count++;
    print_verdict;
  end
  // ==========
  // main sequence
  initial
  begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (c = 0; c < 6; c++)
    begin
      rd(rst_addr[c], v);
      chk("reset value", 8'h00, v);
    end
    // frozen timer keeps its count; a counter write still resets it, capture a ignores writes
    wr(4'h2, 8'h04);
    wr(4'h5, 8'h33);
    rd(4'h5, v);
    chk("counter", 8'hFC, v);
    repeat (40) @(posedge ref_clk);
    rd(4'h6, v);
    chk("mirror", 8'hFC, v);
    wr(4'h3, 8'h55);
    rd(4'h3, v);
    chk("capture a", 8'h00, v);
    wr(4'h2, 8'h00);
    // count parked: slow clock chosen with the oscillator stopped
    wr(4'h0, 8'h0C);
    wr(4'h5, 8'h00);
    wr(4'h1, 8'h82);
    req_a <= 1'b0;
    repeat (8) @(posedge ref_clk);
    st(8'h90, 8'h00);
    req_a <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk("irq", 8'h01, {7'h00, irq_r});
    rd(4'h3, v);
    chk("capture a", 8'hFC, v);
    st(8'h80, 8'h80);
    rd(4'h3, v);
    st(8'h80, 8'h00);
    wr(4'h0, 8'h0E);
    req_b <= 1'b0;
    repeat (8) @(posedge ref_clk);
    st(8'h10, 8'h00);
    wr(4'h0, 8'h0C);
    req_b <= 1'b1;
    repeat (8) @(posedge ref_clk);
    st(8'h10, 8'h00);
    req_b <= 1'b0;
    irq_mask <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk("irq", 8'h00, {7'h00, irq_r});
    chk("wake", 8'h01, {7'h00, wake_r});
    irq_mask <= 1'b0;
    st(8'h10, 8'h10);
    rd(4'h7, v);
    chk("capture b", 8'hFC, v);
    st(8'h10, 8'h00);
    // increments across a span sized to each clock choice: eight, or one for the slow clock
    slow_run <= 1'b1;
    for (c = 0; c < 4; c++)
    begin
      wr(4'h0, {4'h0, sel_tab[c], 2'b00});
      repeat (c == 3 ? 16400 : 8) @(posedge ref_clk);
      rd(4'h5, v);
      repeat (gap[c] - 2) @(posedge ref_clk);
      rd(4'h5, w);
      chk("count step", sel_tab[c] == 2'd3 ? 8'h01 : 8'h08, w - v);
    end
    // overflow survives a mirror access, falls to a counter access
    wr(4'h5, 8'h00);
    repeat (30) @(posedge ref_clk);
    st(8'h20, 8'h20);
    rd(4'h6, v);
    st(8'h20, 8'h20);
    rd(4'h5, v);
    st(8'h20, 8'h00);
    // both compares drive their pins, then forcing overrides
    wr(4'h0, 8'hC4);
    wr(4'h4, 8'h02);
    wr(4'h8, 8'h03);
    wr(4'h1, 8'h05);
    wr(4'h5, 8'h00);
    repeat (30) @(posedge ref_clk);
    chk("pin a", 8'h01, {7'h00, line_a});
    chk("pin b", 8'h01, {7'h00, line_b});
    st(8'h48, 8'h48);
    rd(4'h4, v);
    rd(4'h8, v);
    st(8'h48, 8'h00);
    wr(4'h1, 8'h18);
    repeat (6) @(posedge ref_clk);
    chk("pin a", 8'h00, {7'h00, line_a});
    chk("pin b", 8'h00, {7'h00, line_b});
    wr(4'h2, 8'h04);
    repeat (2) @(posedge ref_clk);
    chk("oe a", 8'h01, {7'h00, oe_a_n});
    wr(4'h2, 8'h00);
    // waveform: reload at compare b, no compare flags, capture a flag per period
    wr(4'h1, 8'h04);
    wr(4'h4, 8'hFE);
    wr(4'h8, 8'h02);
    wr(4'h0, 8'h94);
    // restart the count so the first period ends well inside the rise bound
    wr(4'h5, 8'h00);
    repeat (40) @(posedge ref_clk);
    st(8'h48, 8'h00);
    rd(4'h4, v);
    rd(4'h8, v);
    next_rise(c);
    next_rise(c);
    chk("pwm period", 8'd14, c[7:0]);
    st(8'hC8, 8'h80);
    // single pulse: falling edge on pin a gives one level b pulse, compare a ends it
    wr(4'h0, 8'hA4);
    wr(4'h4, 8'h00);
    wr(4'h5, 8'h00);
    repeat (20) @(posedge ref_clk);
    chk("pulse idle", 8'h00, {7'h00, line_a});
    req_a <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk("pulse on", 8'h01, {7'h00, line_a});
    repeat (20) @(posedge ref_clk);
    chk("pulse off", 8'h00, {7'h00, line_a});
    print_verdict;
  end
endmodule
`default_nettype wire
